// file: rtl/gps_pkg.sv
// Constants, code points and carrier types for the gigabit PCS block
package gps_pkg;
	// ==========================================================
	// Symbol carrier: control flag plus eight data bits
	typedef struct packed {
		logic k;
		logic [7:0] d;
	} gps_sym_s;

	// ==========================================================
	// Code points in the eight-bit domain (y in bits 7:5, x in bits 4:0)
	localparam logic [7:0] GPS_K28_5 = 8'hBC;
	localparam logic [7:0] GPS_D5_6 = 8'hC5;
	localparam logic [7:0] GPS_D16_2 = 8'h50;
	localparam logic [7:0] GPS_D21_5 = 8'hB5;
	localparam logic [7:0] GPS_D2_2 = 8'h42;
	localparam logic [7:0] GPS_K23_7 = 8'hF7;
	localparam logic [7:0] GPS_K27_7 = 8'hFB;
	localparam logic [7:0] GPS_K29_7 = 8'hFD;
	localparam logic [7:0] GPS_K30_7 = 8'hFE;

	// ==========================================================
	// Six-bit and four-bit sub-blocks, negative running disparity form
	localparam logic [5:0] GPS_ENC6 [0:31] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] GPS_ENC4 [0:7] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam logic [3:0] GPS_ENC4_ALT7 = 4'h7;
	localparam logic [5:0] GPS_K28_6B = 6'h0F;
	localparam logic [4:0] GPS_X28 = 5'h1C;
	localparam logic [4:0] GPS_X7 = 5'h07;
	localparam logic [2:0] GPS_Y3 = 3'h3;
	localparam logic [2:0] GPS_Y7 = 3'h7;
	localparam logic GPS_RD_RESET = 1'h0;

	// ==========================================================
	// Synchronisation figures
	localparam logic [1:0] GPS_SYNC_SETS = 2'h3;
	localparam logic [2:0] GPS_LOSS_ERRS = 3'h4;
	localparam logic [1:0] GPS_GOOD_RUN = 2'h3;

	// ==========================================================
	// Rate matcher: fill marks for a 32-word FIFO, +/-100 ppm budget
	localparam int GPS_FIFO_DEPTH = 32;
	localparam logic [5:0] GPS_RM_HI_LVL = 6'h1C;
	localparam logic [5:0] GPS_RM_LO_LVL = 6'h04;
	localparam logic [1:0] GPS_FLAG_CYCLES = 2'h2;

	typedef enum logic {GPS_LOSS, GPS_SYNCED} gps_sync_e;
endpackage

// file: rtl/gps_top.sv
// Gigabit PCS: 8b/10b encoder, code-group sync and rate-match FIFO
// What this block does
// - Encode each eight-bit value with control flag into one ten-bit group.
// - Rate-match FIFO absorbs up to 100 ppm each way, 200 ppm total.
// - No insertion or deletion until code-group sync is reported.
// - Always insert or delete both symbols of an IDLE2 set.
// - Insert or delete as many IDLE2 sets as needed, no gap limit.
// - Deletion flag high two cycles per removed IDLE2 set.
// - Insertion flag high two cycles per added IDLE2 set.
// - IDLE1 is comma plus D5.6, IDLE2 is comma plus D16.2.
// - Carrier extend, start, end, error use K23.7, K27.7, K29.7, K30.7.
// - Sync is declared after three comma-plus-data ordered sets.
// - Sync is dropped when the error count reaches four.
// - Four good groups in a row while synced decrement error count.
// - Fabric clock is 125 MHz or 156.25 MHz depending on line rate.
`timescale 1ns/1ps

// ==========================================================
// Parameterised FIFO with valid/ready on both sides
module gps_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0] wr_ptr_ff, rd_ptr_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign level = wr_ptr_ff - rd_ptr_ff;
	assign in_ready = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data = mem[rd_ptr_ff[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
			rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
		end
	end
endmodule

// ==========================================================
// Top level
module gps_top #(
	parameter int FIFO_DEPTH = gps_pkg::GPS_FIFO_DEPTH
) (
	// Clock and reset: one fabric clock, 125 or 156.25 MHz by line rate
	input wire logic CLK,
	input wire logic RESET,
	// Transmit: symbol in, code group out
	input wire gps_pkg::gps_sym_s TX_SYM,
	output logic [9:0] TX_CODE,
	// Receive: decoded symbols from the deserialiser side
	input wire gps_pkg::gps_sym_s RX_SYM,
	input wire logic RX_ERR,
	input wire logic RX_VALID,
	output logic RX_READY,
	// Receive: rate-matched symbols toward the fabric
	output gps_pkg::gps_sym_s OUT_SYM,
	output logic OUT_VALID,
	input wire logic OUT_READY,
	// Status
	output logic RX_SYNC,
	output logic RM_DELETED,
	output logic RM_INSERTED
);
	// ==========================================================
	// Encoder: returns {new running disparity, abcdei, fghj}
	function automatic logic [10:0] enc_8b10b(input logic k, input logic [7:0] d,
			input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic rd6, bal6, bal4, alt;
		logic [4:0] x;
		logic [2:0] y;
		x = d[4:0];
		y = d[7:5];
		c6 = (k && x == gps_pkg::GPS_X28) ? gps_pkg::GPS_K28_6B : gps_pkg::GPS_ENC6[x];
		bal6 = ($countones(c6) == 3);
		if (rd && (!bal6 || (!k && x == gps_pkg::GPS_X7))) begin
			c6 = ~c6;
		end
		rd6 = bal6 ? rd : !rd;
		alt = (y == gps_pkg::GPS_Y7) && (k
			|| (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
			|| (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
		c4 = alt ? gps_pkg::GPS_ENC4_ALT7 : gps_pkg::GPS_ENC4[y];
		bal4 = ($countones(c4) == 2);
		if (rd6 && (!bal4 || y == gps_pkg::GPS_Y3)) begin
			c4 = ~c4;
		end
		// Comma-bearing K28 flips its balanced trailer too
		if (k && x == gps_pkg::GPS_X28 && bal4 && y != gps_pkg::GPS_Y3 && !rd6) begin
			c4 = ~c4;
		end
		return {bal4 ? rd6 : !rd6, c6, c4};
	endfunction

	function automatic logic is_sym(input gps_pkg::gps_sym_s s, input logic k,
			input logic [7:0] d);
		return (s.k == k) && (s.d == d);
	endfunction

	logic rd_ff;
	logic [9:0] tx_code_ff;
	wire [10:0] enc_res = enc_8b10b(TX_SYM.k, TX_SYM.d, rd_ff);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rd_ff <= gps_pkg::GPS_RD_RESET;
			tx_code_ff <= '0;
		end else begin
			rd_ff <= enc_res[10];
			tx_code_ff <= enc_res[9:0];
		end
	end
	assign TX_CODE = tx_code_ff;

	// ==========================================================
	// Code-group synchronisation
	gps_pkg::gps_sync_e sync_ff;
	logic prev_comma_ff;
	logic [1:0] set_cnt_ff, good_run_ff;
	logic [2:0] err_cnt_ff;
	wire rx_take = RX_VALID && RX_READY;
	wire rx_comma = is_sym(RX_SYM, 1'b1, gps_pkg::GPS_K28_5);
	wire set_done = prev_comma_ff && !RX_SYM.k && !RX_ERR;
	wire [2:0] err_inc = err_cnt_ff + 3'h1;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			sync_ff <= gps_pkg::GPS_LOSS;
			prev_comma_ff <= 1'b0;
			set_cnt_ff <= '0;
			err_cnt_ff <= '0;
			good_run_ff <= '0;
		end else if (rx_take) begin
			prev_comma_ff <= rx_comma && !RX_ERR;
			case (sync_ff)
				gps_pkg::GPS_LOSS: begin
					err_cnt_ff <= '0;
					good_run_ff <= '0;
					if (RX_ERR) begin
						set_cnt_ff <= '0;
					end else if (set_done) begin
						if (set_cnt_ff == gps_pkg::GPS_SYNC_SETS - 2'h1) begin
							sync_ff <= gps_pkg::GPS_SYNCED;
							set_cnt_ff <= '0;
						end else begin
							set_cnt_ff <= set_cnt_ff + 2'h1;
						end
					end
				end
				gps_pkg::GPS_SYNCED: begin
					if (RX_ERR) begin
						good_run_ff <= '0;
						err_cnt_ff <= err_inc;
						if (err_inc == gps_pkg::GPS_LOSS_ERRS) begin
							sync_ff <= gps_pkg::GPS_LOSS;
						end
					end else if (good_run_ff == gps_pkg::GPS_GOOD_RUN) begin
						good_run_ff <= '0;
						if (err_cnt_ff != '0) begin
							err_cnt_ff <= err_cnt_ff - 3'h1;
						end
					end else begin
						good_run_ff <= good_run_ff + 2'h1;
					end
				end
				default: begin
					sync_ff <= gps_pkg::GPS_LOSS;
				end
			endcase
		end
	end
	assign RX_SYNC = (sync_ff == gps_pkg::GPS_SYNCED);

	// ==========================================================
	// Rate matcher, fill side: one symbol held back to see whole IDLE2 sets
	gps_pkg::gps_sym_s hold_ff, f_out;
	logic hold_vld_ff, f_in_ready, f_out_valid, f_pop;
	logic [$clog2(FIFO_DEPTH):0] f_level;
	wire hold_comma = is_sym(hold_ff, 1'b1, gps_pkg::GPS_K28_5);
	wire rx_d16 = is_sym(RX_SYM, 1'b0, gps_pkg::GPS_D16_2) && !RX_ERR;
	// Delete both symbols together so an orphan comma never reaches the fabric
	wire del_evt = rx_take && RX_SYNC && hold_vld_ff && hold_comma && rx_d16
		&& (f_level >= 6'(gps_pkg::GPS_RM_HI_LVL));

	assign RX_READY = f_in_ready || !hold_vld_ff;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			hold_ff <= '0;
			hold_vld_ff <= 1'b0;
		end else if (rx_take) begin
			hold_ff <= RX_SYM;
			hold_vld_ff <= !del_evt;
		end
	end

	gps_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CLK),
		.reset(RESET),
		.in_data(hold_ff),
		.in_valid(rx_take && hold_vld_ff && !del_evt),
		.in_ready(f_in_ready),
		.out_data(f_out),
		.out_valid(f_out_valid),
		.out_ready(f_pop),
		.level(f_level)
	);

	// ==========================================================
	// Rate matcher, drain side: insert after the end of an IDLE2 set
	gps_pkg::gps_sym_s out_ff;
	logic out_vld_ff, ins_half_ff, gap_ff, last_comma_ff;
	wire adv = !out_vld_ff || OUT_READY;
	wire ins_evt = adv && !ins_half_ff && RX_SYNC && gap_ff
		&& (f_level <= 6'(gps_pkg::GPS_RM_LO_LVL));
	assign f_pop = adv && !ins_half_ff && !ins_evt;
	wire emit = ins_half_ff || ins_evt || f_out_valid;
	wire gps_pkg::gps_sym_s nxt_out = ins_half_ff ? {1'b0, gps_pkg::GPS_D16_2}
		: ins_evt ? {1'b1, gps_pkg::GPS_K28_5} : f_out;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			out_ff <= '0;
			out_vld_ff <= 1'b0;
			ins_half_ff <= 1'b0;
			gap_ff <= 1'b0;
			last_comma_ff <= 1'b0;
		end else if (adv) begin
			out_vld_ff <= emit;
			ins_half_ff <= ins_evt;
			if (emit) begin
				out_ff <= nxt_out;
				last_comma_ff <= is_sym(nxt_out, 1'b1, gps_pkg::GPS_K28_5);
				gap_ff <= last_comma_ff && is_sym(nxt_out, 1'b0, gps_pkg::GPS_D16_2);
			end
		end
	end
	assign OUT_SYM = out_ff;
	assign OUT_VALID = out_vld_ff;

	// ==========================================================
	// Event flags, reloaded per set so back-to-back sets stay covered
	logic [1:0] del_cnt_ff, ins_cnt_ff;
	always_ff @(posedge CLK) begin
		if (RESET) begin
			del_cnt_ff <= '0;
			ins_cnt_ff <= '0;
		end else begin
			del_cnt_ff <= del_evt ? gps_pkg::GPS_FLAG_CYCLES
				: del_cnt_ff - 2'(del_cnt_ff != '0);
			ins_cnt_ff <= ins_evt ? gps_pkg::GPS_FLAG_CYCLES
				: ins_cnt_ff - 2'(ins_cnt_ff != '0);
		end
	end
	assign RM_DELETED = (del_cnt_ff != '0);
	assign RM_INSERTED = (ins_cnt_ff != '0);

	// ==========================================================
	// Assertions and covers
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	property p_enc_k28;
		!rd_ff && TX_SYM.k && TX_SYM.d == gps_pkg::GPS_K28_5 |=> TX_CODE == 10'h0FA;
	endproperty
	a_enc_k28: assert property (p_enc_k28) else $error("K28.5 code wrong");
	property p_del_flag;
		del_evt |=> RM_DELETED [*2];
	endproperty
	a_del_flag: assert property (p_del_flag) else $error("delete flag short");
	property p_ins_flag;
		ins_evt |=> RM_INSERTED [*2];
	endproperty
	a_ins_flag: assert property (p_ins_flag) else $error("insert flag short");
	property p_no_rm_unsync;
		!RX_SYNC && !RM_DELETED && !RM_INSERTED |=> !RM_DELETED && !RM_INSERTED;
	endproperty
	a_no_rm_unsync: assert property (p_no_rm_unsync) else $error("match unsynced");
	property p_ins_pair;
		ins_evt |=> OUT_SYM == {1'b1, gps_pkg::GPS_K28_5} && OUT_VALID
			##[1:300] OUT_VALID && $past(OUT_READY) && OUT_SYM == {1'b0, gps_pkg::GPS_D16_2};
	endproperty
	a_ins_pair: assert property (p_ins_pair) else $error("half set inserted");
	property p_loss;
		RX_SYNC && rx_take && RX_ERR && err_cnt_ff == 3'h3 |=> !RX_SYNC;
	endproperty
	a_loss: assert property (p_loss) else $error("sync kept at 4 errors");
	property p_gain;
		!RX_SYNC && rx_take && set_done && set_cnt_ff == 2'h2 |=> RX_SYNC;
	endproperty
	a_gain: assert property (p_gain) else $error("sync not gained");
	property p_decr;
		RX_SYNC && rx_take && !RX_ERR && good_run_ff == 2'h3 && err_cnt_ff != 3'h0
			|=> err_cnt_ff == $past(err_cnt_ff) - 3'h1;
	endproperty
	a_decr: assert property (p_decr) else $error("error count not reduced");
	property p_del_level;
		del_evt |-> f_level >= 6'(gps_pkg::GPS_RM_HI_LVL) && !f_in_ready == 1'b0;
	endproperty
	a_del_level: assert property (p_del_level) else $error("delete below mark");
	c_sync: cover property (!RX_SYNC ##1 RX_SYNC);
	c_del: cover property (del_evt);
	c_ins: cover property (ins_evt);
	c_lost: cover property (RX_SYNC ##1 !RX_SYNC);
endmodule

// file: verification/gps_mac_sink.sv
// Fabric-side sink model that takes rate-matched symbols and tallies them
`timescale 1ns/1ps

// ==========================================================
// Sink with a stall control for prompt acceptance or none at all
module gps_mac_sink (
	// Clock
	input wire logic clk,
	// Symbol stream from the block
	input wire gps_pkg::gps_sym_s sym,
	input wire logic valid,
	output logic ready,
	// Control and tallies
	input wire logic stall,
	output int taken,
	output int commas
);
	initial begin
		ready = 1'b0;
		taken = 0;
		commas = 0;
	end

	// Ready moves only between edges, so a hand-over is never ambiguous
	always @(negedge clk) begin
		ready <= ~stall;
	end

	// Auto-negotiation and carrier sense are not modelled here
	always @(posedge clk) begin
		if (valid === 1'b1 && ready) begin
			taken <= taken + 1;
			if (sym.k && sym.d === gps_pkg::GPS_K28_5) begin
				commas <= commas + 1;
			end
		end
	end
endmodule

// file: verification/gps_top_bench.sv
// Self-checking bench for the PCS block: encoder, sync and rate matcher
`timescale 1ns/1ps

module gps_top_bench;
	// ==========================================================
	// Clock, reset and hookup
	logic clk = 1'b0;
	logic reset = 1'b1;
	gps_pkg::gps_sym_s tx_sym = '0;
	gps_pkg::gps_sym_s rx_sym = '0;
	gps_pkg::gps_sym_s out_sym;
	logic rx_err = 1'b0;
	logic rx_valid = 1'b0;
	logic stall = 1'b1;
	logic [9:0] tx_code;
	logic rx_ready, out_valid, out_ready, rx_sync, rm_del, rm_ins;
	int taken, commas;
	int del_cyc = 0;
	int ins_cyc = 0;
	int miscompares = 0;
	int tests_run = 0;

	always #2 clk = ~clk;

	gps_top #(.FIFO_DEPTH(32)) dut (.CLK(clk), .RESET(reset), .TX_SYM(tx_sym),
		.TX_CODE(tx_code), .RX_SYM(rx_sym), .RX_ERR(rx_err), .RX_VALID(rx_valid),
		.RX_READY(rx_ready), .OUT_SYM(out_sym), .OUT_VALID(out_valid),
		.OUT_READY(out_ready), .RX_SYNC(rx_sync), .RM_DELETED(rm_del),
		.RM_INSERTED(rm_ins));

	gps_mac_sink partner (.clk(clk), .sym(out_sym), .valid(out_valid),
		.ready(out_ready), .stall(stall), .taken(taken), .commas(commas));

	// Flag cycles are tallied so merged back-to-back pulses still count right
	always @(posedge clk) begin
		if (!reset && rm_del === 1'b1) del_cyc <= del_cyc + 1;
		if (!reset && rm_ins === 1'b1) ins_cyc <= ins_cyc + 1;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk);
			rx_valid = 1'b0;
		end
	endtask

	// Holds the symbol until an edge sees ready high
	task automatic send(input logic k, input logic [7:0] d, input logic e);
		int n;
		@(negedge clk);
		rx_sym = {k, d};
		rx_err = e;
		rx_valid = 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (rx_ready === 1'b1) break;
		end
		if (n == 100) begin
			check(16'h0, 16'h1);
			end_of_test();
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic tx_codes();
		logic [8:0] syms [8] = '{{1'b1, gps_pkg::GPS_K28_5},
			{1'b1, gps_pkg::GPS_K28_5}, {1'b1, gps_pkg::GPS_K23_7},
			{1'b1, gps_pkg::GPS_K27_7}, {1'b1, gps_pkg::GPS_K29_7},
			{1'b1, gps_pkg::GPS_K30_7}, {1'b0, gps_pkg::GPS_D21_5},
			{1'b0, gps_pkg::GPS_D2_2}};
		logic [9:0] exp [8] = '{10'h0FA, 10'h305, 10'h3A8, 10'h368, 10'h2E8, 10'h1E8,
			10'h2AA, 10'h2D5};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			@(negedge clk);
			check(16'(tx_code), 16'(exp[i]));
			if (i < 7) tx_sym = syms[i + 1];
		end
	endtask

	// Sink stalled: FIFO reaches the high mark on the edge that sync is gained and climbs past it with the next IDLE2 comma
	task automatic rm_delete();
		repeat (24) send(1'b0, 8'h00, 1'b1);
		for (int i = 1; i <= 5; i++) begin
			send(1'b1, gps_pkg::GPS_K28_5, 1'b0);
			send(1'b0, gps_pkg::GPS_D16_2, 1'b0);
			idle(3);
			if (i == 2) check({rx_sync, 15'(del_cyc)}, 16'h0000);
			if (i == 3) check({rx_sync, 15'(del_cyc)}, 16'h8000);
		end
		idle(4);
		check(16'(del_cyc), 16'h0004);
	endtask

	// Past the first IDLE2 the fill sits at the low mark, so only padding sets drain
	task automatic rm_insert();
		logic pend;
		stall = 1'b0;
		repeat (80) @(negedge clk);
		stall = 1'b1;
		repeat (6) @(negedge clk);
		pend = out_valid && out_sym.k && out_sym.d === gps_pkg::GPS_K28_5;
		check(16'(ins_cyc), 16'(2 * (commas - 1 + int'(pend))));
		check(16'(commas > 4), 16'h1);
	endtask

	// Without the good-run decrement the fourth error would already drop sync
	task automatic sync_loss();
		stall = 1'b0;
		repeat (3) send(1'b0, 8'h11, 1'b1);
		repeat (4) send(1'b0, 8'h22, 1'b0);
		send(1'b0, 8'h33, 1'b1);
		idle(2);
		check(16'(rx_sync), 16'h1);
		send(1'b0, 8'h44, 1'b1);
		idle(2);
		check(16'(rx_sync), 16'h0);
	endtask

	task automatic fill_drain();
		int n, t0, i;
		repeat (60) @(negedge clk);
		stall = 1'b1;
		repeat (2) @(negedge clk);
		t0 = taken;
		rx_sym = {1'b0, 8'h55};
		rx_err = 1'b0;
		rx_valid = 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			if (rx_ready !== 1'b1) break;
		end
		idle(1);
		check(16'(n < 60), 16'h1);
		stall = 1'b0;
		for (i = 0; i < 200 && out_valid !== 1'b0; i++) @(negedge clk);
		repeat (4) @(negedge clk);
		check({out_valid, 15'(taken - t0)}, 16'(n));
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		tx_sym = {1'b1, gps_pkg::GPS_K28_5};
		repeat (10) @(negedge clk);
		check({1'b0, tx_code, out_valid, rx_sync, rm_del, rm_ins, rx_ready}, 16'h0001);
		reset = 1'b0;
		tx_codes();
		rm_delete();
		rm_insert();
		sync_loss();
		fill_drain();
		end_of_test();
	end
endmodule
